/* bench/monitor_status_properties.sv */
`default_nettype none
module monitor_status_properties
  import monitor_status_pkg::*;
(
  input wire logic              CLK_SYS_IN,
  input wire logic              RST_B_IN,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic              AVS_READ_IN,
  input wire logic              AVS_WRITE_IN,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_IN,
  input wire logic [3:0]        AVS_BYTEENABLE_IN,
  input wire logic [DATA_W-1:0] AVS_READDATA_OUT,
  input wire logic              AVS_WAITREQUEST_OUT,
  input wire logic              GENERAL_PIN_SIX_OUT,
  input wire logic              GENERAL_PIN_SIX_OE_OUT,
  input wire logic              FAN_FULL_DUTY_OUT,
  input wire logic              MONITOR_RUN_OUT,
  input wire logic              VOLTAGE_ID_CHANGE_ALERT_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] idx;
  logic       mapped, acc, wr_done, cfg_wr, wbit;
  assign idx     = AVS_ADDRESS_IN[9:2];
  assign mapped  = idx inside {CONFIG_ONE_IDX, STATUS_ONE_IDX, STATUS_TWO_IDX, PIN_CONFIG_IDX}
                   || (idx >= LIMIT_FIRST_IDX && idx <= LIMIT_LAST_IDX);
  assign acc     = (AVS_READ_IN || AVS_WRITE_IN) && !AVS_WAITREQUEST_OUT;
  assign wr_done = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
  assign cfg_wr  = wr_done && idx == CONFIG_ONE_IDX && AVS_BYTEENABLE_IN[0];
  assign wbit    = AVS_WRITEDATA_IN[0];
  default clocking @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RST_B_IN);
  //////////////////////////////////////////////////////////////////////////////
  chk_one_wait:
  assert property ($rose(AVS_READ_IN || AVS_WRITE_IN) |-> AVS_WAITREQUEST_OUT ##1
                   !AVS_WAITREQUEST_OUT) else $error("Request not answered after one wait");
  chk_reset_zero:
  assert property ($rose(RST_B_IN) |-> AVS_READDATA_OUT == '0) else $error("Data after reset");
  chk_stop_full:
  assert property (!MONITOR_RUN_OUT |-> FAN_FULL_DUTY_OUT) else $error("Fans not at full duty");
  chk_run_follows:
  assert property (cfg_wr |=> MONITOR_RUN_OUT == $past(wbit)) else $error("Run bit not written");
  chk_run_cause:
  assert property ($changed(MONITOR_RUN_OUT) |-> $past(cfg_wr)) else $error("Run bit moved");
  chk_pin_write:
  assert property ($changed(GENERAL_PIN_SIX_OUT) |-> $past(wr_done)) else $error("Pin moved");
  chk_pin_enable:
  assert property ($changed(GENERAL_PIN_SIX_OE_OUT) |-> $past(wr_done))
    else $error("Pin enable moved");
  chk_alert_falls:
  assert property ($fell(VOLTAGE_ID_CHANGE_ALERT_OUT) |-> $past(acc)) else $error("Alert fell");
  // Unmapped places must not leak stale data
  chk_unmapped_zero:
  assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT && !mapped |-> AVS_READDATA_OUT == '0)
    else $error("Unmapped read not zero");
endmodule

bind monitor_interrupt_status monitor_status_properties u_monitor_status_properties (
  .CLK_SYS_IN                  (CLK_SYS_IN),
  .RST_B_IN                    (RST_B_IN),
  .AVS_ADDRESS_IN              (AVS_ADDRESS_IN),
  .AVS_READ_IN                 (AVS_READ_IN),
  .AVS_WRITE_IN                (AVS_WRITE_IN),
  .AVS_WRITEDATA_IN            (AVS_WRITEDATA_IN),
  .AVS_BYTEENABLE_IN           (AVS_BYTEENABLE_IN),
  .AVS_READDATA_OUT            (AVS_READDATA_OUT),
  .AVS_WAITREQUEST_OUT         (AVS_WAITREQUEST_OUT),
  .GENERAL_PIN_SIX_OUT         (GENERAL_PIN_SIX_OUT),
  .GENERAL_PIN_SIX_OE_OUT      (GENERAL_PIN_SIX_OE_OUT),
  .FAN_FULL_DUTY_OUT           (FAN_FULL_DUTY_OUT),
  .MONITOR_RUN_OUT             (MONITOR_RUN_OUT),
  .VOLTAGE_ID_CHANGE_ALERT_OUT (VOLTAGE_ID_CHANGE_ALERT_OUT)
);
`default_nettype wire

/* bench/test_monitor_interrupt_status.sv */
`default_nettype none
module test_monitor_interrupt_status
  import monitor_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk, rst_b, rd, wr, ot_above, ot_below, tmr, gp_in;
  logic              wait_r, gp_out, gp_oe, full, run, alert;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, q;
  logic [63:0]       meas;
  logic [3:0]        be, fan_slow;
  logic [2:0]        fan_on;
  logic [1:0]        diode;
  logic [5:0]        voltage_id_code;
  logic [7:0]        m1, m2, c1, s2, k2, pc, v;
  logic [7:0]        lo [8];
  logic [7:0]        hi [8];
  int                n, n_mismatch, tests_run;

  monitor_interrupt_status u_monitor_interrupt_status (
    .CLK_SYS_IN                  (clk),
    .RST_B_IN                    (rst_b),
    .AVS_ADDRESS_IN              (addr),
    .AVS_READ_IN                 (rd),
    .AVS_WRITE_IN                (wr),
    .AVS_WRITEDATA_IN            (wdata),
    .AVS_BYTEENABLE_IN           (be),
    .AVS_READDATA_OUT            (rdata),
    .AVS_WAITREQUEST_OUT         (wait_r),
    .MEAS_VALUE_IN               (meas),
    .OVERTEMP_ABOVE_IN           (ot_above),
    .OVERTEMP_BELOW_HYST_IN      (ot_below),
    .OVERHEAT_TIMER_EXCEEDED_IN  (tmr),
    .FAN_SLOW_IN                 (fan_slow),
    .FAN_DRIVE_ON_IN             (fan_on),
    .DIODE_FAULT_IN              (diode),
    .VOLTAGE_ID_CODE_IN          (voltage_id_code),
    .GENERAL_PIN_SIX_IN          (gp_in),
    .GENERAL_PIN_SIX_OUT         (gp_out),
    .GENERAL_PIN_SIX_OE_OUT      (gp_oe),
    .FAN_FULL_DUTY_OUT           (full),
    .MONITOR_RUN_OUT             (run),
    .VOLTAGE_ID_CHANGE_ALERT_OUT (alert)
  );

  always #50 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ends at a falling edge so callers look at settled outputs
  task automatic bus(input bit w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    @(posedge clk);
    {rd, wr} <= {!w, w};
    addr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wait_r && k < 50);
    if (k >= 50)
    begin
      n_mismatch++;
      print_verdict();
    end
    q = rdata;
    @(posedge clk);
    {rd, wr} <= 2'b00;
    @(negedge clk);
  endtask

  function automatic bit viol(input int g);
    if (g >= 5)
      return $signed(meas[8*g+:8]) > $signed(hi[g]) || $signed(meas[8*g+:8]) <= $signed(lo[g]);
    return meas[8*g+:8] > hi[g] || meas[8*g+:8] <= lo[g];
  endfunction

  // Model latches whatever cause stands once inputs have settled
  task automatic settle;
    repeat (3) @(negedge clk);
    for (int g = 0; g < 4; g++) c1[g] = viol(g);
    for (int g = 5; g < 8; g++) c1[g-1] = viol(g);
    c1[7] = 1'b0;
    if (pc[0]) c1[0] = tmr;
    s2 = {diode, 1'b0, fan_slow[2:0] & fan_on, ot_above, !pc[3] && viol(4)};
    if (pc[2:1] == 2'b00) s2[5] = fan_slow[3] & fan_on[2];
    if (pc[2:1] == 2'b11) s2[5] = tmr;
    k2 = s2;
    k2[1] = ot_above || !ot_below;
    m1 |= c1;
    m2 |= s2;
  endtask

  task automatic rs(input bit two);
    logic [7:0] e;
    e = two ? m2 : {|m2, m1[6:0]};
    bus(1'b0, two ? STATUS_TWO_IDX : STATUS_ONE_IDX, 8'h00);
    chk(two ? "status_two" : "status_one", q, {24'h0, e});
    if (two) m2 &= k2;
    else m1 &= c1;
  endtask

  task automatic rsb;
    rs(1'b0);
    rs(1'b1);
  endtask

  task automatic wlim(input int g, input bit h, input logic [7:0] d);
    if (h) hi[g] = d;
    else lo[g] = d;
    bus(1'b1, 8'(LIMIT_FIRST_IDX + 2 * g + h), d);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    {clk, rst_b, rd, wr, ot_above, ot_below, tmr, gp_in} = '0;
    {addr, wdata, fan_slow, fan_on, diode, m1, m2, c1, s2, k2, pc} = '0;
    {be, voltage_id_code, meas} = {4'hF, 6'h15, 64'h0000_0080_8080_8080};
    for (int g = 0; g < 8; g++) {lo[g], hi[g]} = g < 5 ? {LIMIT_LOW_RST, LIMIT_HIGH_RST}
                                                      : {TEMP_LOW_RST, TEMP_HIGH_RST};
    q = $urandom(68678);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, CONFIG_ONE_IDX, 8'h00);
    chk("config", q, {24'h0, CONFIG_ONE_RST});
    rsb();
    bus(1'b0, 8'h3F, 8'h00);
    chk("unmapped", q, 32'h0);
    bus(1'b1, STATUS_ONE_IDX, 8'hFF);
    bus(1'b1, STATUS_TWO_IDX, 8'hFF);
    rsb();
    // Boundary values: high equal passes, one above fails; low equal fails
    for (int g = 0; g < 8; g++)
    begin
      v = 8'($urandom_range(112, 16));
      @(posedge clk);
      meas[8*g+:8] <= v;
      wlim(g, 1'b1, v);
      settle();
      rsb();
      @(posedge clk);
      meas[8*g+:8] <= v + 8'h01;
      settle();
      rsb();
      rsb();
      wlim(g, 1'b0, v - 8'h05);
      @(posedge clk);
      meas[8*g+:8] <= v - 8'h05;
      settle();
      rsb();
      @(posedge clk);
      meas[8*g+:8] <= v - 8'h04;
      settle();
      rsb();
      rsb();
    end
    repeat (12)
    begin
      @(posedge clk);
      {fan_slow, fan_on, diode, ot_above, ot_below} <= 11'($urandom);
      settle();
      rsb();
    end
    @(posedge clk);
    {fan_slow, fan_on, diode, ot_above, ot_below} <= 11'b10;
    settle();
    rsb();
    @(posedge clk);
    ot_above <= 1'b0;
    settle();
    rsb();
    @(posedge clk);
    ot_below <= 1'b1;
    settle();
    rsb();
    rsb();
    pc = 8'h07;
    bus(1'b1, PIN_CONFIG_IDX, pc);
    @(posedge clk);
    tmr <= 1'b1;
    settle();
    rsb();
    @(posedge clk);
    tmr <= 1'b0;
    settle();
    rsb();
    rsb();
    pc = 8'h02;
    bus(1'b1, PIN_CONFIG_IDX, pc);
    bus(1'b1, STATUS_TWO_IDX, 8'hFF);
    chk("pin_out", {gp_oe, gp_out}, 2'b11);
    bus(1'b0, STATUS_TWO_IDX, 8'h00);
    chk("status_two", q, {24'h0, m2 | 8'h20});
    bus(1'b1, STATUS_TWO_IDX, 8'h00);
    chk("pin_out", gp_out, 1'b0);
    pc = 8'h04;
    bus(1'b1, PIN_CONFIG_IDX, pc);
    @(posedge clk);
    gp_in <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, STATUS_TWO_IDX, 8'h00);
    chk("pin_in", {gp_oe, q[5]}, 2'b01);
    pc = 8'h08;
    bus(1'b1, PIN_CONFIG_IDX, pc);
    settle();
    @(posedge clk);
    voltage_id_code <= voltage_id_code ^ 6'($urandom_range(63, 1));
    n = 0;
    while (!alert && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 300)
    begin
      n_mismatch++;
      print_verdict();
    end
    chk("alert", alert, 1'b1);
    m2[0] = 1'b1;
    rs(1'b1);
    chk("alert", alert, 1'b0);
    chk("run_full", {run, full}, 2'b01);
    bus(1'b1, CONFIG_ONE_IDX, 8'h02);
    bus(1'b1, CONFIG_ONE_IDX, 8'h71);
    chk("run_full", {run, full}, 2'b10);
    bus(1'b0, CONFIG_ONE_IDX, 8'h00);
    chk("config", q, 32'h07);
    bus(1'b1, CONFIG_ONE_IDX, 8'h09);
    chk("run_full", {run, full}, 2'b11);
    @(posedge clk);
    be <= 4'h0;
    bus(1'b1, CONFIG_ONE_IDX, 8'h00);
    chk("run_full", {run, full}, 2'b11);
    @(posedge clk);
    be <= 4'hF;
    bus(1'b1, CONFIG_ONE_IDX, 8'h00);
    chk("run_full", {run, full}, 2'b01);
    print_verdict();
  end
endmodule
`default_nettype wire

/* src/limit_check.sv */
`default_nettype none
module limit_check
  import monitor_status_pkg::*;
#(
  parameter int unsigned WIDTH      = 8,
  parameter bit          SIGNED_CMP = 1'b0
)
(
  input  wire logic [WIDTH-1:0] value_in,
  input  wire logic [WIDTH-1:0] low_in,
  input  wire logic [WIDTH-1:0] high_in,
  output logic                  violation_out
);

  logic                         above;
  logic                         below;

  always_comb
  begin
    if (SIGNED_CMP)
    begin
      above = $signed(value_in) > $signed(high_in);
      below = $signed(value_in) <= $signed(low_in);
    end
    else
    begin
      above = value_in > high_in;
      below = value_in <= low_in;
    end
    violation_out = above | below;
  end

endmodule
`default_nettype wire

/* src/monitor_interrupt_status.sv */
// Behaviour
// - Status one bit 0 flags 2.5 V reading outside its high or low limit.
// - Reading a status register clears a flag only when its cause has gone.
// - With overheat pin mode, status one bit 0 flags overheat timer limit exceeded.
// - Status one bits 1..3 flag core supply, main supply and 5.0 V limits.
// - Status one bits 4..6 flag remote one, local and remote two temperature.
// - Status one bit 7 is the OR of all status two flags.
// - Run control bit stays writable after the configuration lock is set.
// - Monitoring stopped forces every fan drive to full duty.
// - Status two bit 0 flags the 12 V limit in default pin setup.
// - In voltage-ID mode bit 0 flags a code change over 11 us.
// - Voltage-ID change flag is offered as an alert source.
// - Overtemp flag sets above limit; read clears only below limit minus hysteresis.
// - Status two bits 2..4 flag slow fans, never while that drive is off.
// - In speed mode bit 5 flags fan four, suppressed while third drive off.
// - In general-pin mode bit 5 drives the pin or reads its sampled level.
// - In timer mode bit 5 flags overheat assertion time above its limit.
// - Status two bits 6 and 7 flag first and second diode faults.
// - Both status registers reset to zero.
// - High violation is strictly greater; low violation is equal or below.
//
// The Avalon-MM slave port was chosen for this implementation.
`default_nettype none
module monitor_interrupt_status
  import monitor_status_pkg::*;
(
  input  wire logic                    CLK_SYS_IN,
  input  wire logic                    RST_B_IN,
  input  wire logic [ADDR_W-1:0]       AVS_ADDRESS_IN,
  input  wire logic                    AVS_READ_IN,
  input  wire logic                    AVS_WRITE_IN,
  input  wire logic [DATA_W-1:0]       AVS_WRITEDATA_IN,
  input  wire logic [3:0]              AVS_BYTEENABLE_IN,
  output logic      [DATA_W-1:0]       AVS_READDATA_OUT,
  output logic                         AVS_WAITREQUEST_OUT,
  input  wire logic [8*NUM_CHANNELS-1:0] MEAS_VALUE_IN,
  input  wire logic                    OVERTEMP_ABOVE_IN,
  input  wire logic                    OVERTEMP_BELOW_HYST_IN,
  input  wire logic                    OVERHEAT_TIMER_EXCEEDED_IN,
  input  wire logic [3:0]              FAN_SLOW_IN,
  input  wire logic [2:0]              FAN_DRIVE_ON_IN,
  input  wire logic [1:0]              DIODE_FAULT_IN,
  input  wire logic [5:0]              VOLTAGE_ID_CODE_IN,
  input  wire logic                    GENERAL_PIN_SIX_IN,
  output logic                         GENERAL_PIN_SIX_OUT,
  output logic                         GENERAL_PIN_SIX_OE_OUT,
  output logic                         FAN_FULL_DUTY_OUT,
  output logic                         MONITOR_RUN_OUT,
  output logic                         VOLTAGE_ID_CHANGE_ALERT_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    bus_state_t                       bus;
    logic [7:0]                       rdata;
    logic [7:0]                       clr_mask;
    logic [7:0]                       cfg;
    logic [7:0]                       pin_cfg;
    logic [15:0][7:0]                 limits;
    logic [6:0]                       stat_one;
    logic [7:0]                       stat_two;
    logic                             gp_out;
    logic [5:0]                       vid_meta;
    logic [5:0]                       vid_sync;
    logic                             gp_meta;
    logic                             gp_sync;
    logic [5:0]                       vid_snap;
    logic [VID_CNT_W-1:0]             vid_cnt;
  } state_t;

  state_t                             st_ff;
  state_t                             nxt_st;
  logic                               rst_meta_b_ff;
  logic                               rst_sync_b_ff;
  logic [NUM_CHANNELS-1:0]            viol;
  logic [7:0]                         idx;
  logic                               req;
  logic                               accept;
  logic                               rd_one;
  logic                               rd_two;
  logic [6:0]                         cause_one;
  logic [7:0]                         cause_two;
  logic [7:0]                         view_two;
  logic                               vid_change;
  pin_six_mode_t                      six_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_limit(input logic [7:0] i);
    is_limit = (i >= LIMIT_FIRST_IDX) && (i <= LIMIT_LAST_IDX);
  endfunction

  function automatic logic [7:0] limit_reset(input int unsigned n);
    if (n >= 2 * NUM_VOLT)
      limit_reset = n[0] ? TEMP_HIGH_RST : TEMP_LOW_RST;
    else
      limit_reset = n[0] ? LIMIT_HIGH_RST : LIMIT_LOW_RST;
  endfunction

  // Change is checked once per window; a code that reverts within it is missed
  function automatic logic window_last(input logic [VID_CNT_W-1:0] c);
    window_last = (c == VID_CNT_W'(VID_WINDOW_CYC - 1));
  endfunction

  function automatic logic general_mode(input pin_six_mode_t m);
    general_mode = (m == PIN_SIX_GP_OUT) || (m == PIN_SIX_GP_IN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release; the async input never reaches the state struct directly

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      rst_meta_b_ff <= 1'b0;
      rst_sync_b_ff <= 1'b0;
    end
    else
    begin
      rst_meta_b_ff <= 1'b1;
      rst_sync_b_ff <= rst_meta_b_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit comparators, voltages unsigned and temperatures signed

  genvar g;
  generate
    for (g = 0; g < NUM_CHANNELS; g++)
    begin : g_chk
      limit_check #(
        .WIDTH      (8),
        .SIGNED_CMP (g >= NUM_VOLT)
      ) u_chk (
        .value_in      (MEAS_VALUE_IN[8*g +: 8]),
        .low_in        (st_ff.limits[2*g]),
        .high_in       (st_ff.limits[2*g+1]),
        .violation_out (viol[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Decode and causes

  assign idx      = AVS_ADDRESS_IN[9:2];
  assign req      = AVS_READ_IN | AVS_WRITE_IN;
  assign accept   = req && (st_ff.bus == BUS_ACK);
  assign rd_one   = accept && AVS_READ_IN && (idx == STATUS_ONE_IDX);
  assign rd_two   = accept && AVS_READ_IN && (idx == STATUS_TWO_IDX);
  assign six_mode = pin_six_mode_t'(st_ff.pin_cfg[PIN_SIX_LSB +: 2]);
  // code differs from the sample one window back
  assign vid_change = window_last(st_ff.vid_cnt)
                      && (st_ff.vid_sync != st_ff.vid_snap);

  always_comb
  begin
    cause_one[0] = viol[0];
    if (st_ff.pin_cfg[PIN_OVERHEAT_BIT])
      cause_one[0] = OVERHEAT_TIMER_EXCEEDED_IN;
    cause_one[3:1] = viol[3:1];
    cause_one[6:4] = viol[7:5];

    cause_two[0] = viol[CH_TWELVE];
    if (st_ff.pin_cfg[PIN_VIDSEL_BIT])
      cause_two[0] = vid_change;
    cause_two[ST2_OVT_BIT] = OVERTEMP_ABOVE_IN;
    // fan flags gated by their drive
    cause_two[4:2] = FAN_SLOW_IN[2:0] & FAN_DRIVE_ON_IN;
    case (six_mode)
      // fourth fan gated by third drive
      PIN_SIX_SPEED: cause_two[ST2_FIFTH_BIT] = FAN_SLOW_IN[3] & FAN_DRIVE_ON_IN[2];
      PIN_SIX_TIMER: cause_two[ST2_FIFTH_BIT] = OVERHEAT_TIMER_EXCEEDED_IN;
      default:       cause_two[ST2_FIFTH_BIT] = 1'b0;
    endcase
    cause_two[7:6] = DIODE_FAULT_IN;
  end

  // bit 5 shows the pin path in general-pin modes
  always_comb
  begin
    view_two = st_ff.stat_two;
    case (six_mode)
      PIN_SIX_GP_OUT: view_two[ST2_FIFTH_BIT] = st_ff.gp_out;
      PIN_SIX_GP_IN:  view_two[ST2_FIFTH_BIT] = st_ff.gp_sync;
      default:        view_two[ST2_FIFTH_BIT] = st_ff.stat_two[ST2_FIFTH_BIT];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    nxt_st = st_ff;

    // Pin synchronisers
    nxt_st.vid_meta = VOLTAGE_ID_CODE_IN;
    nxt_st.vid_sync = st_ff.vid_meta;
    nxt_st.gp_meta  = GENERAL_PIN_SIX_IN;
    nxt_st.gp_sync  = st_ff.gp_meta;

    if (window_last(st_ff.vid_cnt))
    begin
      nxt_st.vid_cnt  = '0;
      nxt_st.vid_snap = st_ff.vid_sync;
    end
    else
      nxt_st.vid_cnt = st_ff.vid_cnt + VID_CNT_W'(1);

    // Bus: one wait cycle, data loaded during it so it stands at the accept edge
    case (st_ff.bus)
      BUS_IDLE:
      begin
        if (req)
        begin
          nxt_st.bus      = BUS_ACK;
          // Clear mask frozen with the data so a flag set mid-access survives
          nxt_st.rdata    = 8'h00;
          nxt_st.clr_mask = 8'h00;
          if (idx == CONFIG_ONE_IDX)
            nxt_st.rdata = st_ff.cfg;
          else if (idx == STATUS_ONE_IDX)
          begin
            nxt_st.rdata    = {|st_ff.stat_two, st_ff.stat_one};
            nxt_st.clr_mask = {1'b0, st_ff.stat_one};
          end
          else if (idx == STATUS_TWO_IDX)
          begin
            nxt_st.rdata    = view_two;
            nxt_st.clr_mask = st_ff.stat_two;
          end
          else if (idx == PIN_CONFIG_IDX)
            nxt_st.rdata = st_ff.pin_cfg;
          else if (is_limit(idx))
            nxt_st.rdata = st_ff.limits[4'(idx - LIMIT_FIRST_IDX)];
        end
      end
      BUS_ACK:
        nxt_st.bus = BUS_IDLE;
      default:
        nxt_st.bus = BUS_IDLE;
    endcase

    // Register writes, low byte lane only
    if (accept && AVS_WRITE_IN && AVS_BYTEENABLE_IN[0])
    begin
      if (idx == CONFIG_ONE_IDX)
      begin
        if (st_ff.cfg[CFG_LOCK_BIT])
          nxt_st.cfg = (st_ff.cfg & ~CFG_LOCKED_MASK)
                       | (AVS_WRITEDATA_IN[7:0] & CFG_LOCKED_MASK);
        else
          nxt_st.cfg = (st_ff.cfg & ~CFG_WRITE_MASK)
                       | (AVS_WRITEDATA_IN[7:0] & CFG_WRITE_MASK);
      end
      else if (idx == PIN_CONFIG_IDX)
        nxt_st.pin_cfg = AVS_WRITEDATA_IN[7:0];
      else if (is_limit(idx))
        nxt_st.limits[4'(idx - LIMIT_FIRST_IDX)] = AVS_WRITEDATA_IN[7:0];
      // only the general-pin output bit takes a status write
      else if (idx == STATUS_TWO_IDX && six_mode == PIN_SIX_GP_OUT)
        nxt_st.gp_out = AVS_WRITEDATA_IN[ST2_FIFTH_BIT];
    end

    // read clears only flags whose cause is gone; a new event wins
    // clear limited to the addressed register and the bits read out
    nxt_st.stat_one = cause_one
                      | (st_ff.stat_one & ~(rd_one ? st_ff.clr_mask[6:0] : 7'h00));
    nxt_st.stat_two = cause_two
                      | (st_ff.stat_two & ~(rd_two ? st_ff.clr_mask : 8'h00));
    // overtemp holds until below limit minus hysteresis
    if (rd_two && st_ff.clr_mask[ST2_OVT_BIT] && !OVERTEMP_BELOW_HYST_IN)
      nxt_st.stat_two[ST2_OVT_BIT] = 1'b1;
    // Latched bit 5 is meaningless in general-pin modes
    if (general_mode(six_mode))
      nxt_st.stat_two[ST2_FIFTH_BIT] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK_SYS_IN or negedge rst_sync_b_ff)
  begin
    if (!rst_sync_b_ff)
    begin
      st_ff.bus      <= BUS_IDLE;
      st_ff.rdata    <= 8'h00;
      st_ff.clr_mask <= 8'h00;
      st_ff.cfg      <= CONFIG_ONE_RST;
      st_ff.pin_cfg  <= PIN_CONFIG_RST;
      for (int n = 0; n < 16; n++)
        st_ff.limits[n] <= limit_reset(n);
      st_ff.stat_one <= STATUS_RST[6:0];
      st_ff.stat_two <= STATUS_RST;
      st_ff.gp_out   <= 1'b0;
      st_ff.vid_meta <= 6'h00;
      st_ff.vid_sync <= 6'h00;
      st_ff.gp_meta  <= 1'b0;
      st_ff.gp_sync  <= 1'b0;
      st_ff.vid_snap <= 6'h00;
      st_ff.vid_cnt  <= '0;
    end
    else
      st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Waitrequest is combinational: one wait cycle per access
  assign AVS_WAITREQUEST_OUT    = req && (st_ff.bus != BUS_ACK);
  assign AVS_READDATA_OUT       = {24'h000000, st_ff.rdata};
  // pin driven only in output mode
  assign GENERAL_PIN_SIX_OUT    = st_ff.gp_out;
  assign GENERAL_PIN_SIX_OE_OUT = (six_mode == PIN_SIX_GP_OUT);
  assign MONITOR_RUN_OUT        = st_ff.cfg[CFG_RUN_BIT];
  // stopped monitor means full fan duty
  assign FAN_FULL_DUTY_OUT      = !st_ff.cfg[CFG_RUN_BIT] || st_ff.cfg[CFG_FULLSPD_BIT];
  assign VOLTAGE_ID_CHANGE_ALERT_OUT = st_ff.pin_cfg[PIN_VIDSEL_BIT] && st_ff.stat_two[0];

endmodule
`default_nettype wire

/* src/monitor_status_pkg.sv */
`default_nettype none
package monitor_status_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned DATA_W        = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  CONFIG_ONE_IDX   = 8'h40;
  localparam logic [7:0]  STATUS_ONE_IDX   = 8'h41;
  localparam logic [7:0]  STATUS_TWO_IDX   = 8'h42;
  localparam logic [7:0]  LIMIT_FIRST_IDX  = 8'h44;
  localparam logic [7:0]  LIMIT_LAST_IDX   = 8'h53;
  localparam logic [7:0]  PIN_CONFIG_IDX   = 8'hF0;

  // Reset values
  localparam logic [7:0]  CONFIG_ONE_RST   = 8'h04;
  localparam logic [7:0]  STATUS_RST       = 8'h00;
  localparam logic [7:0]  PIN_CONFIG_RST   = 8'h00;
  localparam logic [7:0]  LIMIT_LOW_RST    = 8'h00;
  localparam logic [7:0]  LIMIT_HIGH_RST   = 8'hFF;
  localparam logic [7:0]  TEMP_LOW_RST     = 8'h81;
  localparam logic [7:0]  TEMP_HIGH_RST    = 8'h7F;

  // Configuration register one fields
  localparam int unsigned CFG_RUN_BIT      = 0;
  localparam int unsigned CFG_LOCK_BIT     = 1;
  localparam int unsigned CFG_READY_BIT    = 2;
  localparam int unsigned CFG_FULLSPD_BIT  = 3;
  localparam logic [7:0]  CFG_LOCKED_MASK  = 8'h09;
  localparam logic [7:0]  CFG_WRITE_MASK   = 8'h7B;

  // Pin configuration register fields
  localparam int unsigned PIN_OVERHEAT_BIT = 0;
  localparam int unsigned PIN_SIX_LSB      = 1;
  localparam int unsigned PIN_VIDSEL_BIT   = 3;

  // Status bit positions
  localparam int unsigned ST1_SUMMARY_BIT  = 7;
  localparam int unsigned ST2_FIFTH_BIT    = 5;
  localparam int unsigned ST2_OVT_BIT      = 1;
  localparam int unsigned ST2_FAN_LSB      = 2;
  localparam int unsigned ST2_DIODE_LSB    = 6;

  // Channel layout of the measurement bus
  localparam int unsigned NUM_CHANNELS     = 8;
  localparam int unsigned NUM_VOLT         = 5;
  localparam int unsigned CH_TWELVE        = 4;

  // Voltage-ID change window
  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned VID_WINDOW_NS    = 11000;
  localparam int unsigned VID_WINDOW_CYC   = VID_WINDOW_NS / CLK_PERIOD_NS;
  localparam int unsigned VID_CNT_W        = 8;

  typedef enum logic [1:0] {
    PIN_SIX_SPEED   = 2'b00,
    PIN_SIX_GP_OUT  = 2'b01,
    PIN_SIX_GP_IN   = 2'b10,
    PIN_SIX_TIMER   = 2'b11
  } pin_six_mode_t;

  // One-hot bus phases
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b01,
    BUS_ACK   = 2'b10
  } bus_state_t;

endpackage
`default_nettype wire
